// ==== rtl/fsp_pkg.sv ====
// Operation
// - 00000011 then store within four clocks erases page
// - 00000001 then store loads word into buffer
// - 00000101 then store writes buffer into page
// - cpu stalled until erase or write finishes
// - buffer cleared on write end, clear bit, reset
// - software never loads one buffer entry twice
// - eeprom write during loading discards loaded words
// - buffer load ignores lowest address bit
// - software zeroes non-page address bits on write
// - store enable armed four clocks, held during operation
// - erase and write bits self-clear after done/timeout
// - only five low-bit patterns are valid commands
// - clear bit empties partly filled buffer
// - fuse read plus load within three cycles
// - fuse read bits self-clear after readout or timeout
// - programmed fuse bits read 0, unprogrammed 1
// - eeprom write blocks programming and fuse reads; a store already armed still runs
// - software checks eeprom busy before control write
// - flash operations take 3.7 to 4.5 ms
// - reset does not abort a running flash write
// - software uses same page for erase and write
package fsp_pkg;
  // flash geometry: 32-word pages, 128 pages, byte-addressed pointer
  localparam int unsigned WORD_BITS = 5;
  localparam int unsigned PAGE_BITS = 7;
  localparam int unsigned PAGE_WORDS = 32;
  localparam int unsigned WORD_LSB = 1;
  localparam int unsigned PAGE_LSB = 6;
  // control and status register
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int unsigned CSR_CTL_BITS = 5;
  localparam int unsigned BIT_STORE_EN = 0;
  localparam int unsigned BIT_PAGE_ERASE = 1;
  localparam int unsigned BIT_PAGE_WRITE = 2;
  localparam int unsigned BIT_READ_FUSE = 3;
  localparam int unsigned BIT_CLEAR_BUF = 4;
  // command patterns in the low five bits
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_FUSE = 5'h09;
  localparam logic [4:0] CMD_CLEAR = 5'h11;
  // arming windows in clocks
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] FUSE_WINDOW = 3'h3;
  // configuration byte selectors
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [7:0] CFG_UNMAPPED = 8'hFF;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;
  // flash operation timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FLASH_MIN_TIME_NS = 3700000;
  localparam int unsigned FLASH_MAX_TIME_NS = 4500000;
  localparam int unsigned PROG_MIN_CYCLES = (FLASH_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_MAX_CYCLES = FLASH_MAX_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned OP_CNT_W = 17;
  // user-side operations of the cpu end
  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_ERASE = 3'h1,
    OP_WRITE = 3'h2,
    OP_CLEAR = 3'h3,
    OP_FUSE = 3'h4
  } fsp_op_t;
endpackage

// ==== rtl/fsp_if.sv ====
`timescale 1ns/1ps
interface fsp_if;
  logic csr_we;
  logic [7:0] csr_wdata;
  logic [7:0] csr_rdata;
  logic store_program_instr;
  logic load_program_instr;
  logic [15:0] z;
  logic [15:0] r_word;
  logic lpm_valid;
  logic [7:0] lpm_data;
  logic halt;
  logic ee_busy;
  // controller end
  modport dev (
    input csr_we, csr_wdata, store_program_instr, load_program_instr, z, r_word,
    output csr_rdata, lpm_valid, lpm_data, halt, ee_busy
  );
  // processor end
  modport cpu (
    output csr_we, csr_wdata, store_program_instr, load_program_instr, z, r_word,
    input csr_rdata, lpm_valid, lpm_data, halt, ee_busy
  );
endinterface

// ==== rtl/fsp_ctrl.sv ====
`timescale 1ns/1ps
module fsp_ctrl #(
  parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_MIN_CYCLES
) (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic power_on_rst_i,
  // processor side
  fsp_if.dev cpu,
  // eeprom status
  input wire logic eeprom_write_busy_i,
  input wire logic eeprom_write_start_i,
  // configuration bytes, bit set means programmed
  input wire logic [7:0] lock_prog_i,
  input wire logic [7:0] fuse_low_prog_i,
  input wire logic [7:0] fuse_high_prog_i,
  // flash array
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [fsp_pkg::PAGE_BITS-1:0] flash_page_o,
  input wire logic [fsp_pkg::WORD_BITS-1:0] buf_rd_addr_i,
  output logic [15:0] buf_rd_data_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_HOLD = 2'h3,
    ST_FUSE = 2'h2
  } fsp_dev_state_t;

  fsp_dev_state_t state;
  fsp_dev_state_t next_state;
  logic [4:0] ctl;
  logic [4:0] next_ctl;
  logic [2:0] win_cnt;
  logic [2:0] next_win_cnt;
  logic [15:0] page_buf [fsp_pkg::PAGE_WORDS];
  logic buf_dirty;
  logic op_busy;
  logic op_is_write;
  logic [fsp_pkg::OP_CNT_W-1:0] op_cnt;
  logic [fsp_pkg::PAGE_BITS-1:0] op_page;
  logic lpm_valid;
  logic [7:0] lpm_data;

  // only the five documented patterns are commands
  function automatic logic cmd_known(input logic [4:0] cmd);
    cmd_known = (cmd == fsp_pkg::CMD_LOAD) || (cmd == fsp_pkg::CMD_ERASE) ||
                (cmd == fsp_pkg::CMD_WRITE) || (cmd == fsp_pkg::CMD_FUSE) ||
                (cmd == fsp_pkg::CMD_CLEAR);
  endfunction

  // erase and write are the two operations that stall the cpu
  function automatic logic is_flash_op(input logic [4:0] cmd);
    is_flash_op = (cmd == fsp_pkg::CMD_ERASE) || (cmd == fsp_pkg::CMD_WRITE);
  endfunction

  // configuration byte select; inversion turns programmed bits into zeros
  function automatic logic [7:0] cfg_byte(input logic [15:0] zp, input logic [7:0] lk,
                                           input logic [7:0] fl, input logic [7:0] fh);
    if (zp == fsp_pkg::Z_LOCK) begin
      cfg_byte = ~lk;
    end else if (zp == fsp_pkg::Z_FUSE_LOW) begin
      cfg_byte = ~fl;
    end else if (zp == fsp_pkg::Z_FUSE_HIGH) begin
      cfg_byte = ~fh;
    end else begin
      cfg_byte = fsp_pkg::CFG_UNMAPPED;
    end
  endfunction

  // command decode; writes during an operation or an eeprom write are dropped
  wire [4:0] wr_cmd = cpu.csr_wdata[4:0];
  wire wr_ok = cpu.csr_we && !rst_i && !op_busy && !eeprom_write_busy_i && cmd_known(wr_cmd);
  wire wr_clear = wr_ok && (wr_cmd == fsp_pkg::CMD_CLEAR);
  wire win_open = (win_cnt != 3'h0);
  wire win_last = (win_cnt == 3'h1);
  wire spm_hit = cpu.store_program_instr && !rst_i && (state == ST_ARMED) && win_open;
  wire spm_load = spm_hit && (ctl == fsp_pkg::CMD_LOAD);
  wire spm_op = spm_hit && is_flash_op(ctl);
  wire lpm_hit = cpu.load_program_instr && !rst_i && (state == ST_FUSE) && win_open && !eeprom_write_busy_i;
  wire op_done = op_busy && (op_cnt == fsp_pkg::OP_CNT_W'(1));
  wire [fsp_pkg::WORD_BITS-1:0] load_idx = cpu.z[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_BITS];
  wire [fsp_pkg::PAGE_BITS-1:0] z_page = cpu.z[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_BITS];
  // buffer clear sources; an eeprom write only matters once words are loaded
  wire buf_clear = rst_i || wr_clear || (op_done && op_is_write) ||
                   (eeprom_write_start_i && buf_dirty);

  // status bits of a running operation survive a reset of the sequencer
  wire [4:0] op_bits = op_busy ? ((5'h01 << fsp_pkg::BIT_STORE_EN) |
                       (op_is_write ? (5'h01 << fsp_pkg::BIT_PAGE_WRITE) :
                       (5'h01 << fsp_pkg::BIT_PAGE_ERASE))) : 5'h00;

  // register read and stall, both straight from state
  assign cpu.csr_rdata = {3'h0, ctl | op_bits};
  assign cpu.halt = op_busy;
  assign cpu.ee_busy = eeprom_write_busy_i;
  assign cpu.lpm_valid = lpm_valid;
  assign cpu.lpm_data = lpm_data;
  assign flash_erase_o = op_busy && !op_is_write;
  assign flash_write_o = op_busy && op_is_write;
  assign flash_page_o = op_page;

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_ok) begin
          next_state = (wr_cmd == fsp_pkg::CMD_FUSE) ? ST_FUSE : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (spm_op) begin
          next_state = ST_HOLD;
        end else if (spm_hit) begin
          next_state = ST_IDLE;
        end else if (wr_ok) begin
          next_state = (wr_cmd == fsp_pkg::CMD_FUSE) ? ST_FUSE : ST_ARMED;
        end else if (win_last) begin
          next_state = ST_IDLE;
        end
      end
      ST_FUSE: begin
        // a fresh write outranks the window running out, or the new command would be lost
        if (wr_ok) begin
          next_state = (wr_cmd == fsp_pkg::CMD_FUSE) ? ST_FUSE : ST_ARMED;
        end else if (lpm_hit || win_last) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (op_done || !op_busy) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // control bits follow the sequencer; idle means all bits cleared
  always_comb begin
    if (next_state == ST_IDLE) begin
      next_ctl = 5'h00;
    end else if (wr_ok && (state != ST_HOLD)) begin
      next_ctl = wr_cmd;
    end else begin
      next_ctl = ctl;
    end
    if (wr_ok) begin
      next_win_cnt = (wr_cmd == fsp_pkg::CMD_FUSE) ? fsp_pkg::FUSE_WINDOW : fsp_pkg::STORE_WINDOW;
    end else if (win_open) begin
      next_win_cnt = win_cnt - 3'h1;
    end else begin
      next_win_cnt = 3'h0;
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      ctl <= fsp_pkg::CSR_RESET[4:0];
      win_cnt <= 3'h0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      win_cnt <= next_win_cnt;
    end
  end

  // flash operation timer; only power-on clears it so a system reset cannot cut a write short
  always_ff @(posedge ref_clk_i) begin
    if (power_on_rst_i) begin
      op_busy <= 1'b0;
      op_is_write <= 1'b0;
      op_cnt <= '0;
      op_page <= '0;
    end else if (spm_op) begin
      op_busy <= 1'b1;
      op_is_write <= (ctl == fsp_pkg::CMD_WRITE);
      op_cnt <= fsp_pkg::OP_CNT_W'(PROG_CYCLES);
      op_page <= z_page;
    end else if (op_busy) begin
      op_cnt <= op_cnt - fsp_pkg::OP_CNT_W'(1);
      if (op_done) begin
        op_busy <= 1'b0;
      end
    end
  end

  // temporary page buffer; a clear resets every entry at once
  always_ff @(posedge ref_clk_i) begin
    if (buf_clear) begin
      for (int i = 0; i < fsp_pkg::PAGE_WORDS; i++) begin
        page_buf[i] <= fsp_pkg::BUF_ERASED;
      end
      buf_dirty <= 1'b0;
    end else if (spm_load) begin
      page_buf[load_idx] <= cpu.r_word;
      buf_dirty <= 1'b1;
    end
  end

  // array-side read port, registered
  always_ff @(posedge ref_clk_i) begin
    buf_rd_data_o <= page_buf[buf_rd_addr_i];
  end

  // configuration byte readout, one cycle after the load instruction
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lpm_valid <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_valid <= lpm_hit;
      if (lpm_hit) begin
        lpm_data <= cfg_byte(cpu.z, lock_prog_i, fuse_low_prog_i, fuse_high_prog_i);
      end
    end
  end
endmodule // fsp_ctrl

// ==== rtl/fsp_cpu.sv ====
`timescale 1ns/1ps
module fsp_cpu (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // controller side
  fsp_if.cpu cpu,
  // user command port
  input wire logic cmd_valid_i,
  input wire fsp_pkg::fsp_op_t cmd_i,
  input wire logic [15:0] z_i,
  input wire logic [15:0] data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic err_o,
  output logic [7:0] rdata_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_EE = 3'h1,
    H_CSR = 3'h3,
    H_ISSUE = 3'h2,
    H_WAIT = 3'h6
  } fsp_cpu_state_t;

  fsp_cpu_state_t state;
  fsp_pkg::fsp_op_t op;
  logic [15:0] z_q;
  logic [15:0] data_q;
  logic [fsp_pkg::PAGE_WORDS-1:0] loaded;
  logic erased_valid;
  logic [fsp_pkg::PAGE_BITS-1:0] erased_page;

  // command pattern for each user operation
  function automatic logic [4:0] op_cmd(input fsp_pkg::fsp_op_t o);
    case (o)
      fsp_pkg::OP_LOAD: op_cmd = fsp_pkg::CMD_LOAD;
      fsp_pkg::OP_ERASE: op_cmd = fsp_pkg::CMD_ERASE;
      fsp_pkg::OP_WRITE: op_cmd = fsp_pkg::CMD_WRITE;
      fsp_pkg::OP_CLEAR: op_cmd = fsp_pkg::CMD_CLEAR;
      fsp_pkg::OP_FUSE: op_cmd = fsp_pkg::CMD_FUSE;
      default: op_cmd = 5'h00;
    endcase
  endfunction

  // request checks; refusing here is cheaper than a corrupted page
  wire [fsp_pkg::WORD_BITS-1:0] in_word = z_i[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_BITS];
  wire [fsp_pkg::PAGE_BITS-1:0] in_page = z_i[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_BITS];
  wire reload = (cmd_i == fsp_pkg::OP_LOAD) && loaded[in_word];
  wire page_clash = (cmd_i == fsp_pkg::OP_WRITE) && erased_valid && (in_page != erased_page);
  wire take = cmd_valid_i && (state == H_IDLE);
  wire is_op = (op == fsp_pkg::OP_ERASE) || (op == fsp_pkg::OP_WRITE);
  wire [15:0] page_mask = {{(16 - fsp_pkg::PAGE_LSB - fsp_pkg::PAGE_BITS){1'b0}},
                           {fsp_pkg::PAGE_BITS{1'b1}}, {fsp_pkg::PAGE_LSB{1'b0}}};
  wire [fsp_pkg::WORD_BITS-1:0] q_word = z_q[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_BITS];

  // bus strobes come straight from the state
  assign cmd_ready_o = (state == H_IDLE);
  assign cpu.csr_we = (state == H_CSR);
  assign cpu.csr_wdata = {3'h0, op_cmd(op)};
  assign cpu.store_program_instr = (state == H_ISSUE) && (op != fsp_pkg::OP_FUSE);
  assign cpu.load_program_instr = (state == H_ISSUE) && (op == fsp_pkg::OP_FUSE);
  assign cpu.z = (op == fsp_pkg::OP_WRITE) ? (z_q & page_mask) : z_q;
  assign cpu.r_word = data_q;

  // command sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= H_IDLE;
      op <= fsp_pkg::OP_LOAD;
      z_q <= 16'h0000;
      data_q <= 16'h0000;
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 8'h00;
      loaded <= '0;
      erased_valid <= 1'b0;
      erased_page <= '0;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      case (state)
        H_IDLE: begin
          if (take && (reload || page_clash)) begin
            err_o <= 1'b1;
          end else if (take) begin
            op <= cmd_i;
            z_q <= z_i;
            data_q <= data_i;
            state <= H_EE;
          end
        end
        H_EE: begin
          if (!cpu.ee_busy) begin
            state <= H_CSR;
          end
        end
        H_CSR: begin
          if (op == fsp_pkg::OP_CLEAR) begin
            loaded <= '0;
            done_o <= 1'b1;
            state <= H_IDLE;
          end else begin
            state <= H_ISSUE;
          end
        end
        H_ISSUE: begin
          if (op == fsp_pkg::OP_LOAD) begin
            loaded[q_word] <= 1'b1;
            done_o <= 1'b1;
            state <= H_IDLE;
          end else begin
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (!is_op) begin
            rdata_o <= cpu.lpm_data;
            done_o <= cpu.lpm_valid;
            err_o <= !cpu.lpm_valid;
            state <= H_IDLE;
          end else if (!cpu.halt) begin
            // a stall that never came means the command was dropped
            done_o <= cpu.csr_rdata[fsp_pkg::BIT_STORE_EN] == 1'b0;
            if (op == fsp_pkg::OP_ERASE) begin
              erased_valid <= 1'b1;
              erased_page <= z_q[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_BITS];
            end else begin
              erased_valid <= 1'b0;
              loaded <= '0;
            end
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule // fsp_cpu

// ==== dv/fsp_chk.sv ====
`timescale 1ns/1ps
module fsp_chk #(
  parameter int unsigned PROG_CYCLES = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // controller side of the link
  input wire logic [7:0] csr_rdata_i,
  input wire logic spm_i,
  input wire logic lpm_i,
  input wire logic lpm_valid_i,
  input wire logic halt_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [16:0] halt_cnt;
  // run length of the stall; system reset must not cut it short
  always_ff @(posedge ref_clk_i) begin
    halt_cnt <= halt_i ? halt_cnt + 17'h00001 : 17'h00000;
  end
  property p_rsv; csr_rdata_i[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits nonzero");
  property p_op_start;
    spm_i && !halt_i && (csr_rdata_i[4:0] == 5'h03 || csr_rdata_i[4:0] == 5'h05)
      |=> halt_i && csr_rdata_i[4:0] == $past(csr_rdata_i[4:0]);
  endproperty
  a_op_start: assert property (p_op_start) else $error("erase or write did not stall");
  property p_load; spm_i && csr_rdata_i[4:0] == 5'h01 |=> csr_rdata_i[4:0] == 5'h00 && !halt_i; endproperty
  a_load: assert property (p_load) else $error("buffer store left bits set");
  property p_halt_len; $fell(halt_i) |-> halt_cnt == PROG_CYCLES; endproperty
  a_halt_len: assert property (p_halt_len) else $error("stall length wrong");
  property p_halt_bits; halt_i |-> csr_rdata_i[0] && csr_rdata_i[2:1] != 2'h0; endproperty
  a_halt_bits: assert property (p_halt_bits) else $error("bits dropped during operation");
  property p_halt_cause; $rose(halt_i) |-> $past(spm_i); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("stall without store");
  property p_op_end; $fell(halt_i) |-> csr_rdata_i[4:0] == 5'h00; endproperty
  a_op_end: assert property (p_op_end) else $error("bits not cleared at end");
  property p_fuse; lpm_i && csr_rdata_i[4:0] == 5'h09 |=> lpm_valid_i && csr_rdata_i[4:0] == 5'h00; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse readout missing");
  property p_lpm_pulse; lpm_valid_i |=> !lpm_valid_i; endproperty
  a_lpm_pulse: assert property (p_lpm_pulse) else $error("readout longer than one cycle");
endmodule // fsp_chk

// ==== dv/flash_self_program_ctrl_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module flash_self_program_ctrl_bench;
  logic clk = 0, rst = 1, por = 1, ee_busy = 0, ee_start = 0, cmd_valid = 0;
  fsp_pkg::fsp_op_t cmd = fsp_pkg::OP_LOAD;
  logic [15:0] zi = 0, di = 0, bdata;
  logic [4:0] rd_addr = 0;
  logic [7:0] lock_p = 8'h03, fl_p = 8'h62, fh_p = 8'hD9, rdata, last_op;
  logic ready, done, err, fe, fw;
  logic [6:0] page;
  int n_errors = 0, n_tests = 0, n;
  fsp_if ifa();
  fsp_if ifb();
  // second controller is driven by hand so windows and refusals can be forced
  fsp_ctrl #(.PROG_CYCLES(8)) i_fsp_ctrl (.ref_clk_i(clk), .rst_i(rst), .power_on_rst_i(por), .cpu(ifa.dev),
    .eeprom_write_busy_i(ee_busy), .eeprom_write_start_i(ee_start), .lock_prog_i(lock_p), .fuse_low_prog_i(fl_p),
    .fuse_high_prog_i(fh_p), .flash_erase_o(fe), .flash_write_o(fw), .flash_page_o(page), .buf_rd_addr_i(rd_addr),
    .buf_rd_data_o(bdata));
  fsp_ctrl #(.PROG_CYCLES(8)) i_fsp_ctrl_b (.ref_clk_i(clk), .rst_i(rst), .power_on_rst_i(por), .cpu(ifb.dev),
    .eeprom_write_busy_i(ee_busy), .eeprom_write_start_i(ee_start), .lock_prog_i(lock_p), .fuse_low_prog_i(fl_p),
    .fuse_high_prog_i(fh_p), .flash_erase_o(), .flash_write_o(), .flash_page_o(), .buf_rd_addr_i(rd_addr),
    .buf_rd_data_o());
  fsp_cpu i_fsp_cpu (.ref_clk_i(clk), .rst_i(rst), .cpu(ifa.cpu), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .z_i(zi), .data_i(di), .cmd_ready_o(ready), .done_o(done), .err_o(err), .rdata_o(rdata));
  fsp_chk #(.PROG_CYCLES(8)) i_fsp_chk (.ref_clk_i(clk), .rst_i(rst), .csr_rdata_i(ifa.csr_rdata), .spm_i(ifa.store_program_instr),
    .lpm_i(ifa.load_program_instr), .lpm_valid_i(ifa.lpm_valid), .halt_i(ifa.halt));
  // remember kind and page of the last flash operation seen on the array
  always @(posedge clk) begin
    if (fe | fw) last_op <= {fw, page};
  end
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one host command, held until taken, then wait for done or err
  task automatic run(input fsp_pkg::fsp_op_t op, input logic [15:0] zz, input logic [15:0] dd);
    int i;
    @(negedge clk);
    cmd_valid = 1;
    cmd = op;
    zi = zz;
    di = dd;
    for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
    if (i == 50) begin n_errors++; print_verdict(); end
    @(negedge clk);
    cmd_valid = 0;
    for (i = 0; i < 50 && done !== 1'b1 && err !== 1'b1; i++) @(negedge clk);
    if (i == 50) begin n_errors++; print_verdict(); end
  endtask
  // buffer read has one cycle of latency
  task automatic buf_is(input logic [4:0] a, input logic [15:0] ex);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    `CHK("buffer", ex, bdata)
  endtask
  // control write then an instruction k cycles after the write edge
  task automatic win(input logic [7:0] v, input bit ld, input int k, input logic [7:0] ecsr, input logic ex);
    @(negedge clk);
    ifb.csr_we = 1;
    ifb.csr_wdata = v;
    @(negedge clk);
    ifb.csr_we = 0;
    `CHK("csr", ecsr, ifb.csr_rdata)
    repeat (k - 1) @(negedge clk);
    ifb.store_program_instr = !ld;
    ifb.load_program_instr = ld;
    @(negedge clk);
    ifb.store_program_instr = 0;
    ifb.load_program_instr = 0;
    `CHK("accepted", ex, ld ? ifb.lpm_valid : ifb.halt)
  endtask
  // count stalled cycles; reset is released after rel+1 of them
  task automatic settle(input int rel);
    for (n = 0; n < 20 && ifb.halt !== 1'b0; n++) begin
      @(negedge clk);
      if (n == rel) rst = 0;
    end
  endtask
  task automatic t_page();
    run(fsp_pkg::OP_CLEAR, 16'h0000, 16'h0000);
    run(fsp_pkg::OP_LOAD, 16'h0001, 16'hA5C3);
    run(fsp_pkg::OP_LOAD, 16'h003F, 16'h3C5A);
    buf_is(5'h00, 16'hA5C3);
    buf_is(5'h1F, 16'h3C5A);
    buf_is(5'h01, 16'hFFFF);
    run(fsp_pkg::OP_ERASE, 16'h0155, 16'h1234);
    `CHK("erase", 8'h05, last_op)
    run(fsp_pkg::OP_WRITE, 16'h0155, 16'h0000);
    `CHK("write", 8'h85, last_op)
    buf_is(5'h00, 16'hFFFF);
  endtask
  task automatic t_refuse();
    run(fsp_pkg::OP_LOAD, 16'h0006, 16'h1111);
    run(fsp_pkg::OP_LOAD, 16'h0006, 16'h2222);
    `CHK("reload", 1'b1, err)
    // the clash needs a prior erase of another page to compare against
    run(fsp_pkg::OP_ERASE, 16'h0140, 16'h0000);
    run(fsp_pkg::OP_WRITE, 16'h0180, 16'h0000);
    `CHK("page", 1'b1, err)
    run(fsp_pkg::OP_CLEAR, 16'h0000, 16'h0000);
    run(fsp_pkg::OP_LOAD, 16'h0004, 16'h0F0F);
    @(negedge clk);
    ee_start = 1;
    @(negedge clk);
    ee_start = 0;
    buf_is(5'h02, 16'hFFFF);
    // a busy eeprom must hold the host back; a host that ignored it would be idle again by now
    ee_busy = 1;
    fork
      run(fsp_pkg::OP_LOAD, 16'h0008, 16'h5555);
      begin
        repeat (6) @(negedge clk);
        `CHK("ee wait", 1'b0, ready)
        ee_busy = 0;
      end
    join
    buf_is(5'h04, 16'h5555);
    run(fsp_pkg::OP_CLEAR, 16'h0000, 16'h0000);
    buf_is(5'h04, 16'hFFFF);
  endtask
  task automatic t_fuse();
    logic [15:0] zs [3] = '{16'h0001, 16'h0000, 16'h0003};
    logic [7:0] ex [3];
    ex = '{~lock_p, ~fl_p, ~fh_p};
    for (int j = 0; j < 3; j++) begin
      run(fsp_pkg::OP_FUSE, zs[j], 16'h0000);
      `CHK("fuse", ex[j], rdata)
    end
  endtask
  task automatic t_window();
    logic [7:0] bad [6] = '{8'h00, 8'h02, 8'h07, 8'h1F, 8'h0D, 8'h13};
    win(8'h03, 0, 4, 8'h03, 1'b1);
    settle(0);
    `CHK("stall", 8, n)
    `CHK("cleared", 8'h00, ifb.csr_rdata)
    win(8'h03, 0, 5, 8'h03, 1'b0);
    win(8'h09, 1, 3, 8'h09, 1'b1);
    win(8'h09, 1, 4, 8'h09, 1'b0);
    foreach (bad[i]) win(bad[i], 0, 1, 8'h00, 1'b0);
    ee_busy = 1;
    win(8'h09, 1, 1, 8'h00, 1'b0);
    win(8'h03, 0, 1, 8'h00, 1'b0);
    ee_busy = 0;
  endtask
  // reset in mid-erase must leave the stall running to its full length
  task automatic t_reset();
    run(fsp_pkg::OP_LOAD, 16'h000E, 16'h7777);
    win(8'h03, 0, 1, 8'h03, 1'b1);
    rst = 1;
    settle(1);
    `CHK("reset stall", 8, n)
    buf_is(5'h07, 16'hFFFF);
  endtask
  // main sequence; both resets held together at start
  initial begin
    ifb.csr_we = 0;
    ifb.csr_wdata = 8'h00;
    ifb.store_program_instr = 0;
    ifb.load_program_instr = 0;
    ifb.z = 16'h0001;
    ifb.r_word = 16'h0000;
    repeat (8) @(negedge clk);
    rst = 0;
    por = 0;
    t_page();
    t_refuse();
    t_fuse();
    t_window();
    t_reset();
    print_verdict();
  end
endmodule // flash_self_program_ctrl_bench
